// ---- rtl/fat_pkg.sv ----
// Constants, register map and limit-window function for the alarm limit bank
`default_nettype none
package fat_pkg;
   // Register offsets
   localparam logic [7:0] FAT_ADDR_CTRL = 8'h48;
   localparam logic [7:0] FAT_ADDR_GEN_LIMITS = 8'h49;
   localparam logic [7:0] FAT_ADDR_SEL_LIMITS = 8'h4a;
   localparam logic [7:0] FAT_ADDR_IRQ_STATUS = 8'h50;
   localparam logic [7:0] FAT_ADDR_IRQ_MASK = 8'h51;
   localparam logic [7:0] FAT_ADDR_SOFT_LO = 8'h52;
   localparam logic [7:0] FAT_ADDR_SOFT_HI = 8'h53;
   localparam logic [7:0] FAT_ADDR_HARD_LO = 8'h54;
   localparam logic [7:0] FAT_ADDR_HARD_HI = 8'h55;

   // Reset values
   localparam logic [7:0] FAT_RST_CTRL = 8'h03;
   localparam logic [7:0] FAT_RST_GEN_LIMITS = 8'h23;
   localparam logic [7:0] FAT_RST_SEL_LIMITS = 8'h23;
   localparam logic [2:0] FAT_RST_IRQ_MASK = 3'h0;
   localparam logic [3:0] FAT_RST_HARD_FIELD = 4'h3;
   localparam logic [3:0] FAT_RST_SEL_SOFT_FIELD = 4'h2;

   // Field positions
   localparam int FAT_CTRL_HARD_EN = 0;
   localparam int FAT_CTRL_SOFT_EN = 1;
   localparam int FAT_CTRL_PHASE_BUILDOUT_ENABLE = 2;
   localparam int FAT_LIM_SOFT_HI = 7;
   localparam int FAT_LIM_SOFT_LO = 4;
   localparam int FAT_LIM_HARD_HI = 3;
   localparam int FAT_LIM_HARD_LO = 0;
   localparam int FAT_IRQ_HARD = 0;
   localparam int FAT_IRQ_SOFT = 1;
   localparam int FAT_IRQ_PBO = 2;
   localparam int FAT_IRQ_BITS = 3;

   // Offsets measured in hundredths of a ppm; one limit step is 3.81 ppm
   localparam int FAT_OFFSET_W = 16;
   localparam int FAT_STEP_CPPM = 381;
   localparam int FAT_MAX_SRC = 16;

   // True when the offset lies outside +/-(lim+1) steps
   function automatic logic fat_exceeds(input logic signed [FAT_OFFSET_W-1:0] off,
                                        input logic [3:0] lim);
      logic [FAT_OFFSET_W-1:0] mag;
      logic [31:0] win;
      begin
         mag = off[FAT_OFFSET_W-1] ? FAT_OFFSET_W'(-off) : FAT_OFFSET_W'(off);
         win = (32'(lim) + 32'h1) * 32'(FAT_STEP_CPPM);
         return 32'(mag) > win;
      end
   endfunction
endpackage
`default_nettype wire

// ---- rtl/fat_config.sv ----
// Frequency alarm limit bank with monitor compare and phase build-out control
// Summary of operation
// - Build-out enable set: build-out event per source switch; clear: lock zero phase.
// - One eight-bit register holds general soft limit [7:4] and hard limit [3:0].
// - A limit field means a window of +/-(value+1) times 3.81 ppm.
// - Hard limit fields reset to 0011, four limit steps.
// - Selected-source soft limit field resets to 0010, three limit steps.
// - Selected source uses its own limit pair; others use the general pair.
`timescale 1ns/1ps
`default_nettype none
module fat_config
   import fat_pkg::*;
#(
   parameter int N_SRC = 14
)(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Frequency measurements, one per source
   input wire logic [N_SRC-1:0][fat_pkg::FAT_OFFSET_W-1:0] i_src_offset,
   input wire logic [N_SRC-1:0] i_meas_valid,
   // Source selection
   input wire logic [3:0] i_sel_src,
   input wire logic i_sel_valid,
   input wire logic i_src_switch,
   // Alarms and build-out control
   output logic [N_SRC-1:0] o_soft_alarm,
   output logic [N_SRC-1:0] o_hard_alarm,
   output logic o_pbo_event,
   output logic o_lock_zero_phase,
   output logic o_irq
);
   import fat_pkg::*;

   generate
      if (N_SRC < 1 || N_SRC > FAT_MAX_SRC)
      begin : g_bad_n
         $error("N_SRC must lie between 1 and 16");
      end
   endgenerate

   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] gen_lim_r, gen_lim_nxt;
   logic [7:0] sel_lim_r, sel_lim_nxt;
   logic [FAT_IRQ_BITS-1:0] irq_stat_r, irq_stat_nxt;
   logic [FAT_IRQ_BITS-1:0] irq_mask_r, irq_mask_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [N_SRC-1:0] soft_r, soft_nxt;
   logic [N_SRC-1:0] hard_r, hard_nxt;
   logic pbo_r, pbo_nxt;
   logic [FAT_MAX_SRC-1:0] soft_ext, hard_ext;
   logic [FAT_IRQ_BITS-1:0] irq_evt;
   logic hard_en, soft_en, phase_buildout_enable;

   assign hard_en = ctrl_r[FAT_CTRL_HARD_EN];
   assign soft_en = ctrl_r[FAT_CTRL_SOFT_EN];
   assign phase_buildout_enable = ctrl_r[FAT_CTRL_PHASE_BUILDOUT_ENABLE];

   // Configuration registers
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      gen_lim_nxt = gen_lim_r;
      sel_lim_nxt = sel_lim_r;
      irq_mask_nxt = irq_mask_r;
      if (i_wr)
      begin
         if (i_addr == FAT_ADDR_CTRL)
            ctrl_nxt = {5'h0, i_wdata[2:0]};
         else if (i_addr == FAT_ADDR_GEN_LIMITS)
            gen_lim_nxt = i_wdata;
         else if (i_addr == FAT_ADDR_SEL_LIMITS)
            sel_lim_nxt = i_wdata;
         else if (i_addr == FAT_ADDR_IRQ_MASK)
            irq_mask_nxt = i_wdata[FAT_IRQ_BITS-1:0];
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ctrl_r <= FAT_RST_CTRL;
         gen_lim_r <= FAT_RST_GEN_LIMITS;
         sel_lim_r <= FAT_RST_SEL_LIMITS;
         irq_mask_r <= FAT_RST_IRQ_MASK;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         gen_lim_r <= gen_lim_nxt;
         sel_lim_r <= sel_lim_nxt;
         irq_mask_r <= irq_mask_nxt;
      end
   end

   // Monitor compare: alarms are refreshed per measurement strobe
   always_comb
   begin
      soft_nxt = soft_r;
      hard_nxt = hard_r;
      for (int i = 0; i < N_SRC; i++)
      begin
         logic is_sel;
         logic [3:0] s_lim;
         logic [3:0] h_lim;
         is_sel = i_sel_valid && (32'(i_sel_src) == i);
         s_lim = is_sel ? sel_lim_r[FAT_LIM_SOFT_HI:FAT_LIM_SOFT_LO]
                        : gen_lim_r[FAT_LIM_SOFT_HI:FAT_LIM_SOFT_LO];
         h_lim = is_sel ? sel_lim_r[FAT_LIM_HARD_HI:FAT_LIM_HARD_LO]
                        : gen_lim_r[FAT_LIM_HARD_HI:FAT_LIM_HARD_LO];
         if (!soft_en)
            soft_nxt[i] = 1'b0;
         else if (i_meas_valid[i])
            soft_nxt[i] = fat_exceeds(i_src_offset[i], s_lim);
         if (!hard_en)
            hard_nxt[i] = 1'b0;
         else if (i_meas_valid[i])
            hard_nxt[i] = fat_exceeds(i_src_offset[i], h_lim);
      end
   end

   // Build-out and interrupt state
   always_comb
   begin
      pbo_nxt = i_src_switch && phase_buildout_enable;
      irq_evt = '0;
      irq_evt[FAT_IRQ_HARD] = |(hard_nxt & ~hard_r);
      irq_evt[FAT_IRQ_SOFT] = |(soft_nxt & ~soft_r);
      irq_evt[FAT_IRQ_PBO] = pbo_nxt;
      irq_stat_nxt = irq_stat_r;
      // Write-one-to-clear; a new event in the same cycle wins
      if (i_wr && i_addr == FAT_ADDR_IRQ_STATUS)
         irq_stat_nxt = irq_stat_nxt & ~i_wdata[FAT_IRQ_BITS-1:0];
      irq_stat_nxt = irq_stat_nxt | irq_evt;
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         soft_r <= '0;
         hard_r <= '0;
         pbo_r <= 1'b0;
         irq_stat_r <= '0;
      end
      else
      begin
         soft_r <= soft_nxt;
         hard_r <= hard_nxt;
         pbo_r <= pbo_nxt;
         irq_stat_r <= irq_stat_nxt;
      end
   end

   // Read path; data valid only in the cycle after the strobe
   always_comb
   begin
      soft_ext = '0;
      hard_ext = '0;
      soft_ext[N_SRC-1:0] = soft_r;
      hard_ext[N_SRC-1:0] = hard_r;
      rdata_nxt = 8'h00;
      if (i_rd)
      begin
         if (i_addr == FAT_ADDR_CTRL)
            rdata_nxt = ctrl_r;
         else if (i_addr == FAT_ADDR_GEN_LIMITS)
            rdata_nxt = gen_lim_r;
         else if (i_addr == FAT_ADDR_SEL_LIMITS)
            rdata_nxt = sel_lim_r;
         else if (i_addr == FAT_ADDR_IRQ_STATUS)
            rdata_nxt = {5'h0, irq_stat_r};
         else if (i_addr == FAT_ADDR_IRQ_MASK)
            rdata_nxt = {5'h0, irq_mask_r};
         else if (i_addr == FAT_ADDR_SOFT_LO)
            rdata_nxt = soft_ext[7:0];
         else if (i_addr == FAT_ADDR_SOFT_HI)
            rdata_nxt = soft_ext[15:8];
         else if (i_addr == FAT_ADDR_HARD_LO)
            rdata_nxt = hard_ext[7:0];
         else if (i_addr == FAT_ADDR_HARD_HI)
            rdata_nxt = hard_ext[15:8];
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         rdata_r <= 8'h00;
      else
         rdata_r <= rdata_nxt;
   end

   assign o_rdata = rdata_r;
   assign o_soft_alarm = soft_r;
   assign o_hard_alarm = hard_r;
   assign o_pbo_event = pbo_r;
   assign o_lock_zero_phase = !phase_buildout_enable;
   assign o_irq = |(irq_stat_r & irq_mask_r);

   property p_pbo_event;
      @(posedge i_mclk) disable iff (!i_reset_n)
      i_src_switch && o_lock_zero_phase |=> !o_pbo_event;
   endproperty
   a_pbo_event: assert property (p_pbo_event) else $error("build-out event while disabled");

   property p_pbo_fire;
      @(posedge i_mclk) disable iff (!i_reset_n)
      i_src_switch && !o_lock_zero_phase |=> o_pbo_event ##0 irq_stat_r[FAT_IRQ_PBO];
   endproperty
   a_pbo_fire: assert property (p_pbo_fire) else $error("missing build-out event");

   property p_gen_write;
      @(posedge i_mclk) disable iff (!i_reset_n)
      i_wr && i_addr == FAT_ADDR_GEN_LIMITS |=> gen_lim_r == $past(i_wdata);
   endproperty
   a_gen_write: assert property (p_gen_write) else $error("general limits not stored");

   property p_hard_default;
      @(posedge i_mclk) disable iff (!i_reset_n)
      $rose(i_reset_n) |-> gen_lim_r[3:0] == 4'h3 && sel_lim_r[3:0] == 4'h3;
   endproperty
   a_hard_default: assert property (p_hard_default) else $error("hard limit reset value wrong");

   property p_sel_soft_default;
      @(posedge i_mclk) disable iff (!i_reset_n)
      $rose(i_reset_n) |-> sel_lim_r[7:4] == 4'h2;
   endproperty
   a_sel_soft_default: assert property (p_sel_soft_default) else $error("soft limit reset wrong");

   property p_hard_off;
      @(posedge i_mclk) disable iff (!i_reset_n)
      !hard_en |=> o_hard_alarm == '0;
   endproperty
   a_hard_off: assert property (p_hard_off) else $error("hard alarm while disabled");

   property p_src0_hard;
      @(posedge i_mclk) disable iff (!i_reset_n)
      i_meas_valid[0] && hard_en |=> o_hard_alarm[0] == fat_exceeds($past(i_src_offset[0]),
         $past((i_sel_valid && i_sel_src == 4'h0) ? sel_lim_r[3:0] : gen_lim_r[3:0]));
   endproperty
   a_src0_hard: assert property (p_src0_hard) else $error("source zero hard compare wrong");

   property p_src0_soft;
      @(posedge i_mclk) disable iff (!i_reset_n)
      i_meas_valid[0] && soft_en && !(i_sel_valid && i_sel_src == 4'h0) |=>
         o_soft_alarm[0] == fat_exceeds($past(i_src_offset[0]), $past(gen_lim_r[7:4]));
   endproperty
   a_src0_soft: assert property (p_src0_soft) else $error("source zero soft compare wrong");

   property p_src0_sel_soft;
      @(posedge i_mclk) disable iff (!i_reset_n)
      i_meas_valid[0] && soft_en && i_sel_valid && i_sel_src == 4'h0 |=>
         o_soft_alarm[0] == fat_exceeds($past(i_src_offset[0]), $past(sel_lim_r[FAT_LIM_SOFT_HI:FAT_LIM_SOFT_LO]));
   endproperty
   a_src0_sel_soft: assert property (p_src0_sel_soft) else $error("selected soft compare wrong");

   property p_sel_write;
      @(posedge i_mclk) disable iff (!i_reset_n)
      i_wr && i_addr == FAT_ADDR_SEL_LIMITS |=> sel_lim_r == $past(i_wdata);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("selected limits not stored");

   property p_soft_off;
      @(posedge i_mclk) disable iff (!i_reset_n)
      !soft_en |=> o_soft_alarm == '0;
   endproperty
   a_soft_off: assert property (p_soft_off) else $error("soft alarm while disabled");

   property p_irq_set_wins;
      @(posedge i_mclk) disable iff (!i_reset_n)
      irq_evt != '0 |=> (irq_stat_r & $past(irq_evt)) == $past(irq_evt);
   endproperty
   a_irq_set_wins: assert property (p_irq_set_wins) else $error("status event lost");

   property p_no_switch;
      @(posedge i_mclk) disable iff (!i_reset_n)
      !i_src_switch |=> !o_pbo_event;
   endproperty
   a_no_switch: assert property (p_no_switch) else $error("build-out event without switch");

   property p_rdata_idle;
      @(posedge i_mclk) disable iff (!i_reset_n)
      !i_rd |=> o_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule // fat_config
`default_nettype wire

// ---- bench/fat_config_test.sv ----
// Self-checking bench for the frequency alarm limit bank
`timescale 1ns/1ps
`default_nettype none
module fat_config_test;
   import fat_pkg::*;
   localparam int NS = 14;
   logic i_mclk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic [NS-1:0][FAT_OFFSET_W-1:0] i_src_offset = '0;
   logic [NS-1:0] i_meas_valid = '0;
   logic [3:0] i_sel_src = 4'h0;
   logic i_sel_valid = 1'b0;
   logic i_src_switch = 1'b0;
   logic [NS-1:0] o_soft_alarm;
   logic [NS-1:0] o_hard_alarm;
   logic o_pbo_event;
   logic o_lock_zero_phase;
   logic o_irq;
   int fail_count = 0;
   int num_checks = 0;
   logic [7:0] rd_val;

   fat_config #(.N_SRC(NS)) i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src_offset(i_src_offset),
      .i_meas_valid(i_meas_valid), .i_sel_src(i_sel_src), .i_sel_valid(i_sel_valid),
      .i_src_switch(i_src_switch), .o_soft_alarm(o_soft_alarm), .o_hard_alarm(o_hard_alarm),
      .o_pbo_event(o_pbo_event), .o_lock_zero_phase(o_lock_zero_phase), .o_irq(o_irq));

   initial
   begin
      forever #20 i_mclk = ~i_mclk;
   end

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Ends one ns past the write edge so register updates have landed
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      rd_val = o_rdata;
      chk(what, exp, rd_val);
   endtask

   task automatic meas(input int s, input int off);
      @(posedge i_mclk);
      i_src_offset[s] <= 16'(off);
      i_meas_valid[s] <= 1'b1;
      @(posedge i_mclk);
      i_meas_valid <= '0;
      #1;
   endtask

   task automatic sw(input logic exp);
      @(posedge i_mclk);
      i_src_switch <= 1'b1;
      @(posedge i_mclk);
      i_src_switch <= 1'b0;
      #1;
      chk("pbo_pulse", {7'h0, exp}, {7'h0, o_pbo_event});
      @(posedge i_mclk);
      #1;
      chk("pbo_end", 8'h00, {7'h0, o_pbo_event});
   endtask

   // Window is (field+1) steps of 381 hundredths of a ppm, strictly exceeded
   function automatic logic [7:0] exc(input int off, input logic [3:0] lim);
      int mag;
      mag = (off < 0) ? -off : off;
      return {7'h0, mag > (int'(lim) + 1) * 381};
   endfunction

   initial
   begin
      repeat (5000) @(posedge i_mclk);
      fail_count++;
      tally_and_finish();
   end

   initial
   begin
      logic [7:0] g;
      logic [7:0] c;
      int s;
      int p;
      int off;
      void'($urandom(32'h6314));
      repeat (3) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      rdchk("gen_limits_rst", FAT_ADDR_GEN_LIMITS, 8'h23);
      rdchk("sel_limits_rst", FAT_ADDR_SEL_LIMITS, 8'h23);
      rdchk("ctrl_rst", FAT_ADDR_CTRL, 8'h03);
      rdchk("unmapped", 8'h60, 8'h00);
      chk("lock_zero_rst", 8'h01, {7'h0, o_lock_zero_phase});
      for (int k = 0; k < 12; k++)
      begin
         g = (k == 0) ? 8'hf0 : 8'($urandom);
         c = (k == 0) ? 8'h0f : 8'($urandom);
         // Selection moves around; first two passes pin source zero both ways
         p = (k < 2) ? k : int'($urandom_range(NS - 1, 0));
         s = (k == 1) ? 0 : (p + 1 + int'($urandom_range(NS - 2, 0))) % NS;
         @(posedge i_mclk);
         i_sel_valid <= 1'b1;
         i_sel_src <= 4'(p);
         wr(FAT_ADDR_GEN_LIMITS, g);
         wr(FAT_ADDR_SEL_LIMITS, c);
         rdchk("gen_rb", FAT_ADDR_GEN_LIMITS, g);
         rdchk("sel_rb", FAT_ADDR_SEL_LIMITS, c);
         // Hard window edge, just inside or just outside, both signs
         off = ((int'(g[3:0]) + 1) * 381 + (k % 2)) * ((k % 4 < 2) ? 1 : -1);
         meas(s, off);
         chk("hard_gen", exc(off, g[3:0]), {7'h0, o_hard_alarm[s]});
         chk("soft_gen", exc(off, g[7:4]), {7'h0, o_soft_alarm[s]});
         meas(p, off);
         chk("hard_sel", exc(off, c[3:0]), {7'h0, o_hard_alarm[p]});
         chk("soft_sel", exc(off, c[7:4]), {7'h0, o_soft_alarm[p]});
      end
      // Selection dropped: last selected source falls back to the general pair
      @(posedge i_mclk);
      i_sel_valid <= 1'b0;
      meas(p, off);
      chk("hard_unsel", exc(off, g[3:0]), {7'h0, o_hard_alarm[p]});
      chk("soft_unsel", exc(off, g[7:4]), {7'h0, o_soft_alarm[p]});
      meas(3, 32767);
      chk("alarms_set", 8'h03, {6'h0, o_hard_alarm[3], o_soft_alarm[3]});
      wr(FAT_ADDR_CTRL, 8'h00);
      @(posedge i_mclk);
      #1;
      chk("alarms_disabled", 8'h00, {6'h0, o_hard_alarm[3], o_soft_alarm[3]});
      wr(FAT_ADDR_CTRL, 8'h03);
      meas(5, 0);
      wr(FAT_ADDR_IRQ_MASK, 8'h00);
      wr(FAT_ADDR_IRQ_STATUS, 8'h07);
      meas(5, 32767);
      rdchk("irq_status", FAT_ADDR_IRQ_STATUS, 8'h03);
      meas(12, -32768);
      rdchk("hard_lo", FAT_ADDR_HARD_LO, 8'h20);
      rdchk("hard_hi", FAT_ADDR_HARD_HI, 8'h10);
      rdchk("soft_lo", FAT_ADDR_SOFT_LO, 8'h20);
      rdchk("soft_hi", FAT_ADDR_SOFT_HI, 8'h10);
      chk("irq_masked", 8'h00, {7'h0, o_irq});
      wr(FAT_ADDR_IRQ_MASK, 8'h03);
      rdchk("mask_rb", FAT_ADDR_IRQ_MASK, 8'h03);
      @(posedge i_mclk);
      #1;
      chk("irq_on", 8'h01, {7'h0, o_irq});
      wr(FAT_ADDR_IRQ_STATUS, 8'h03);
      @(posedge i_mclk);
      #1;
      chk("irq_cleared", 8'h00, {7'h0, o_irq});
      wr(FAT_ADDR_IRQ_MASK, 8'h04);
      wr(FAT_ADDR_CTRL, 8'h07);
      chk("lock_zero_off", 8'h00, {7'h0, o_lock_zero_phase});
      sw(1'b1);
      chk("irq_pbo", 8'h01, {7'h0, o_irq});
      wr(FAT_ADDR_CTRL, 8'hfb);
      rdchk("ctrl_upper", FAT_ADDR_CTRL, 8'h03);
      chk("lock_zero_on", 8'h01, {7'h0, o_lock_zero_phase});
      sw(1'b0);
      tally_and_finish();
   end
endmodule // fat_config_test
`default_nettype wire
